// ==== hdl/pmx_signal_mux.sv ====
/*
  Pin function mux for ports B, C and D plus PWM fault and pair source
  selection, with its select registers on a classic Wishbone slave.
  Assumes one 50 MHz clock, peripherals and ADC on that clock, and pin
  levels arriving asynchronously.
*/
`timescale 1ns/1ps
`include "pmx_regs.svh"

// Contract
// - Lower B bit 2 picks pin B1: SPI0 slave select, or I2C data.
// - Lower B bit 0 picks pin B0: SPI0 clock, or I2C clock.
// - Upper B bit 8 picks pin B11: comparator B, or timer B1.
// - Upper B bit 6 picks pin B10: comparator A, or timer B0.
// - Upper B bit 4 picks pin B9: I2C data, or CAN receive.
// - Upper B bit 2 picks pin B8: I2C clock, or CAN transmit.
// - Upper B bit 0 picks pin B7: serial 0 transmit, or I2C clock.
// - C/D bit 12 picks pin D5: crystal output, or external clock in.
// - C/D bit 4 picks pin C12: ADC B channel 4, or serial 1 receive.
// - C/D bit 2 picks pin C8: ADC A channel 4, or serial 1 transmit.
// - PWM source bit 13 feeds fault two from pin or comparator B.
// - PWM source bit 11 feeds fault one from pin or comparator A.
// - Bits 8..6 choose pair 4/5 source: pin, A3, ADC, cmp A, cmp B.
// - ADC mode pair 4/5: above high gives 0/1, below low 1/0.
// - Bits 5..3 choose pair 2/3 source: pin, A2, ADC, cmp A, cmp B.
// - ADC mode pair 2/3: above high gives 0/1, below low 1/0.
// - Bits 2..0 choose pair 0/1 source: pin, A0, ADC, cmp A, cmp B.
// - ADC mode pair 0/1: above high gives 0/1, below low 1/0.
// - Peripheral enable low gives pin to GPIO; high lets selects decide.
module pmx_signal_mux #(
  parameter int ADC_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [`PMX_NPIN-1:0] pad_in_i,
  output logic [`PMX_NPIN-1:0] pad_o,
  output logic [`PMX_NPIN-1:0] pad_oe_o,
  input wire logic [`PMX_NPIN-1:0] gpio_o_i,
  input wire logic [`PMX_NPIN-1:0] gpio_oe_i,
  input wire logic [`PMX_NPIN-1:0] pin_peripheral_enable_i,
  output logic [`PMX_NPIN-1:0] gpio_in_o,
  input wire pmx_pkg::pmx_per_out_t per_drv_i,
  output pmx_pkg::pmx_per_in_t per_in_o,
  input wire logic comparator_a_output_i,
  input wire logic comparator_b_output_i,
  input wire logic [2:0] pair_timer_i,
  input wire logic [1:0] fault_pin_i,
  input wire logic [2:0] pair_pin_i,
  input wire logic [2:0][ADC_W-1:0] adc_result_i,
  input wire logic [2:0][ADC_W-1:0] adc_high_limit_i,
  input wire logic [2:0][ADC_W-1:0] adc_low_limit_i,
  output logic [1:0] fault_o,
  output pmx_pkg::pmx_pair_t [2:0] pair_o
);
  import pmx_pkg::*;

  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] wd,
                                       input logic [3:0] be,
                                       input logic [15:0] msk);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    return v & msk;
  endfunction

  function automatic pmx_pair_t pair_drive(input logic [2:0] code,
                                           input logic pin,
                                           input logic tmr,
                                           input logic ca,
                                           input logic cb,
                                           input pmx_pair_t adc);
    pmx_pair_t p;
    logic s;
    s = 1'b0;
    p = '0;
    case (code)
      `PMX_SRC_PIN: s = pin;
      `PMX_SRC_TMR: s = tmr;
      `PMX_SRC_CMPA: s = ca;
      `PMX_SRC_CMPB: s = cb;
      default: s = 1'b0;
    endcase
    case (code)
      `PMX_SRC_PIN, `PMX_SRC_TMR, `PMX_SRC_CMPA, `PMX_SRC_CMPB: begin
        p.even = s;
        p.odd = ~s;
      end
      `PMX_SRC_ADC: p = adc;
      default: p = '0;
    endcase
    return p;
  endfunction

  // Register file
  logic [15:0] gpsb_lo_reg;
  logic [15:0] gpsb_hi_reg;
  logic [15:0] pcd_sel_reg;
  logic [15:0] ips_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [5:0] idx;
  logic req;
  logic wr;

  assign idx = adr_i[7:2];
  assign req = cyc_i & stb_i;
  // Write lands on the same edge at which the master sees ack
  assign wr = req & we_i & ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpsb_lo_reg <= `PMX_RST16;
      gpsb_hi_reg <= `PMX_RST16;
      pcd_sel_reg <= `PMX_RST16;
      ips_reg <= `PMX_RST16;
    end else if (wr) begin
      // Masks keep reserved bits at zero
      case (idx)
        `PMX_IDX_GPSB_LO: gpsb_lo_reg <= wr16(gpsb_lo_reg, dat_i, sel_i, `PMX_MSK_GPSB_LO);
        `PMX_IDX_GPSB_HI: gpsb_hi_reg <= wr16(gpsb_hi_reg, dat_i, sel_i, `PMX_MSK_GPSB_HI);
        `PMX_IDX_PCD: pcd_sel_reg <= wr16(pcd_sel_reg, dat_i, sel_i, `PMX_MSK_PCD);
        `PMX_IDX_IPS: ips_reg <= wr16(ips_reg, dat_i, sel_i, `PMX_MSK_IPS);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (req & ~ack_reg & ~we_i) begin
      // Unmapped addresses read zero and are still acknowledged
      case (idx)
        `PMX_IDX_GPSB_LO: dat_reg <= {16'h0000, gpsb_lo_reg};
        `PMX_IDX_GPSB_HI: dat_reg <= {16'h0000, gpsb_hi_reg};
        `PMX_IDX_PCD: dat_reg <= {16'h0000, pcd_sel_reg};
        `PMX_IDX_IPS: dat_reg <= {16'h0000, ips_reg};
        default: dat_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  // Three-stage pin synchroniser; a level counts once stages 2 and 3 agree
  logic [`PMX_NEXT-1:0] ext;
  logic [`PMX_NEXT-1:0] s1_reg;
  logic [`PMX_NEXT-1:0] s2_reg;
  logic [`PMX_NEXT-1:0] s3_reg;
  logic [`PMX_NEXT-1:0] lvl_reg;
  logic [`PMX_NPIN-1:0] lvl;

  assign ext = {pair_pin_i, fault_pin_i, pad_in_i};
  assign lvl = lvl_reg[`PMX_NPIN-1:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg <= ext;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
    end
  end

  // Per-pin function A (select 0) and B (select 1)
  logic [`PMX_NPIN-1:0] a_o;
  logic [`PMX_NPIN-1:0] a_oe;
  logic [`PMX_NPIN-1:0] b_o;
  logic [`PMX_NPIN-1:0] b_oe;
  logic [`PMX_NPIN-1:0] sel;
  logic [`PMX_NPIN-1:0] take_a;
  logic [`PMX_NPIN-1:0] take_b;

  always_comb begin
    sel = '0;
    sel[`PMX_PIN_B0] = gpsb_lo_reg[`PMX_B0_BIT];
    sel[`PMX_PIN_B1] = gpsb_lo_reg[`PMX_B1_BIT];
    sel[`PMX_PIN_B7] = gpsb_hi_reg[`PMX_B7_BIT];
    sel[`PMX_PIN_B8] = gpsb_hi_reg[`PMX_B8_BIT];
    sel[`PMX_PIN_B9] = gpsb_hi_reg[`PMX_B9_BIT];
    sel[`PMX_PIN_B10] = gpsb_hi_reg[`PMX_B10_BIT];
    sel[`PMX_PIN_B11] = gpsb_hi_reg[`PMX_B11_BIT];
    sel[`PMX_PIN_C8] = pcd_sel_reg[`PMX_C8_BIT];
    sel[`PMX_PIN_C12] = pcd_sel_reg[`PMX_C12_BIT];
    sel[`PMX_PIN_D5] = pcd_sel_reg[`PMX_D5_BIT];
  end

  always_comb begin
    // Input-only functions leave their slot undriven
    a_o = '0;
    a_oe = '0;
    b_o = '0;
    b_oe = '0;
    {a_o[`PMX_PIN_B0], a_oe[`PMX_PIN_B0]} = per_drv_i.spi0_serial_clock;
    {b_o[`PMX_PIN_B0], b_oe[`PMX_PIN_B0]} = per_drv_i.i2c_scl;
    {a_o[`PMX_PIN_B1], a_oe[`PMX_PIN_B1]} = per_drv_i.spi0_slave_select;
    {b_o[`PMX_PIN_B1], b_oe[`PMX_PIN_B1]} = per_drv_i.i2c_sda;
    {a_o[`PMX_PIN_B7], a_oe[`PMX_PIN_B7]} = per_drv_i.serial0_transmit;
    {b_o[`PMX_PIN_B7], b_oe[`PMX_PIN_B7]} = per_drv_i.i2c_scl;
    {a_o[`PMX_PIN_B8], a_oe[`PMX_PIN_B8]} = per_drv_i.i2c_scl;
    {b_o[`PMX_PIN_B8], b_oe[`PMX_PIN_B8]} = per_drv_i.can_transmit_data;
    {a_o[`PMX_PIN_B9], a_oe[`PMX_PIN_B9]} = per_drv_i.i2c_sda;
    {a_o[`PMX_PIN_B10], a_oe[`PMX_PIN_B10]} = {comparator_a_output_i, 1'b1};
    {b_o[`PMX_PIN_B10], b_oe[`PMX_PIN_B10]} = per_drv_i.timer_b0;
    {a_o[`PMX_PIN_B11], a_oe[`PMX_PIN_B11]} = {comparator_b_output_i, 1'b1};
    {b_o[`PMX_PIN_B11], b_oe[`PMX_PIN_B11]} = per_drv_i.timer_b1;
    {b_o[`PMX_PIN_C8], b_oe[`PMX_PIN_C8]} = per_drv_i.serial1_transmit;
    {a_o[`PMX_PIN_D5], a_oe[`PMX_PIN_D5]} = per_drv_i.crystal_osc_output;
  end

  assign take_a = pin_peripheral_enable_i & ~sel;
  assign take_b = pin_peripheral_enable_i & sel;

  logic [`PMX_NPIN-1:0] pad_reg;
  logic [`PMX_NPIN-1:0] oe_reg;
  logic [`PMX_NPIN-1:0] gin_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_reg <= '0;
      oe_reg <= '0;
      gin_reg <= '0;
    end else begin
      // GPIO owns a pin unless its peripheral enable is set
      pad_reg <= (take_a & a_o) | (take_b & b_o) | (~pin_peripheral_enable_i & gpio_o_i);
      oe_reg <= (take_a & a_oe) | (take_b & b_oe) | (~pin_peripheral_enable_i & gpio_oe_i);
      gin_reg <= lvl;
    end
  end

  assign pad_o = pad_reg;
  assign pad_oe_o = oe_reg;
  assign gpio_in_o = gin_reg;

  // Peripheral inputs; several pins on I2C combine wired-AND, idle high
  logic [`PMX_NPIN-1:0] scl_m;
  logic [`PMX_NPIN-1:0] sda_m;
  pmx_per_in_t pin_reg;

  always_comb begin
    scl_m = '0;
    sda_m = '0;
    scl_m[`PMX_PIN_B0] = take_b[`PMX_PIN_B0];
    scl_m[`PMX_PIN_B7] = take_b[`PMX_PIN_B7];
    scl_m[`PMX_PIN_B8] = take_a[`PMX_PIN_B8];
    sda_m[`PMX_PIN_B1] = take_b[`PMX_PIN_B1];
    sda_m[`PMX_PIN_B9] = take_a[`PMX_PIN_B9];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_reg <= '0;
    end else begin
      pin_reg.spi0_serial_clock <= take_a[`PMX_PIN_B0] & lvl[`PMX_PIN_B0];
      pin_reg.spi0_slave_select <= take_a[`PMX_PIN_B1] & lvl[`PMX_PIN_B1];
      pin_reg.i2c_scl <= &(~scl_m | lvl);
      pin_reg.i2c_sda <= &(~sda_m | lvl);
      pin_reg.can_receive_data <= take_b[`PMX_PIN_B9] & lvl[`PMX_PIN_B9];
      pin_reg.serial1_receive <= take_b[`PMX_PIN_C12] & lvl[`PMX_PIN_C12];
      pin_reg.external_clock_input <= take_b[`PMX_PIN_D5] & lvl[`PMX_PIN_D5];
      pin_reg.adc_a_channel_four <= take_a[`PMX_PIN_C8] & lvl[`PMX_PIN_C8];
      pin_reg.adc_b_channel_four <= take_a[`PMX_PIN_C12] & lvl[`PMX_PIN_C12];
    end
  end

  assign per_in_o = pin_reg;

  // PWM fault sources
  logic [1:0] flt_reg;
  logic [1:0] flt_pin;

  assign flt_pin = lvl_reg[`PMX_NPIN+1:`PMX_NPIN];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flt_reg <= 2'h0;
    end else begin
      flt_reg[0] <= ips_reg[`PMX_FLT1_BIT] ? comparator_a_output_i : flt_pin[0];
      flt_reg[1] <= ips_reg[`PMX_FLT2_BIT] ? comparator_b_output_i : flt_pin[1];
    end
  end

  assign fault_o = flt_reg;

  // PWM pair sources; ADC state tracks always so a mode switch sees it fresh
  logic [2:0][2:0] code;
  pmx_pair_t [2:0] adc_st_reg;
  pmx_pair_t [2:0] pair_reg;

  assign code[0] = ips_reg[`PMX_P01_LSB +: 3];
  assign code[1] = ips_reg[`PMX_P23_LSB +: 3];
  assign code[2] = ips_reg[`PMX_P45_LSB +: 3];

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pair
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          adc_st_reg[g] <= '0;
          pair_reg[g] <= '0;
        end else begin
          // Above high: even 0, odd 1; below low: even 1, odd 0
          if (adc_result_i[g] > adc_high_limit_i[g]) begin
            adc_st_reg[g] <= 2'h1;
          end else if (adc_result_i[g] < adc_low_limit_i[g]) begin
            adc_st_reg[g] <= 2'h2;
          end
          // Between limits the state holds reserved codes give 0/0
          pair_reg[g] <= pair_drive(code[g], lvl_reg[`PMX_NPIN+2+g], pair_timer_i[g],
                                    comparator_a_output_i, comparator_b_output_i,
                                    adc_st_reg[g]);
        end
      end
    end
  endgenerate

  assign pair_o = pair_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");
  a_reserved_zero: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0000 &&
    ((idx != `PMX_IDX_IPS) || (dat_o[15:14] == 2'h0)))
    else $error("reserved bits read non-zero");
  a_gpio_owns_pin: assert property (!pin_peripheral_enable_i[`PMX_PIN_B0] |=>
    pad_o[`PMX_PIN_B0] == $past(gpio_o_i[`PMX_PIN_B0]))
    else $error("gpio lost pin B0");
  a_b0_i2c_clock: assert property (pin_peripheral_enable_i[`PMX_PIN_B0] &&
    gpsb_lo_reg[`PMX_B0_BIT] |=> pad_o[`PMX_PIN_B0] == $past(per_drv_i.i2c_scl.o))
    else $error("pin B0 not I2C clock");
  a_b1_spi_select: assert property (pin_peripheral_enable_i[`PMX_PIN_B1] &&
    !gpsb_lo_reg[`PMX_B1_BIT] |=> pad_oe_o[`PMX_PIN_B1] ==
    $past(per_drv_i.spi0_slave_select.oe))
    else $error("pin B1 not SPI select");
  a_b10_cmp_out: assert property (pin_peripheral_enable_i[`PMX_PIN_B10] &&
    !gpsb_hi_reg[`PMX_B10_BIT] |=> pad_o[`PMX_PIN_B10] == $past(comparator_a_output_i))
    else $error("pin B10 not comparator A");
  a_b8_can_tx: assert property (pin_peripheral_enable_i[`PMX_PIN_B8] &&
    gpsb_hi_reg[`PMX_B8_BIT] |=> pad_o[`PMX_PIN_B8] == $past(per_drv_i.can_transmit_data.o))
    else $error("pin B8 not CAN transmit");
  a_fault_cmp_b: assert property (ips_reg[`PMX_FLT2_BIT] |=>
    fault_o[1] == $past(comparator_b_output_i))
    else $error("fault two not comparator B");
  a_fault_cmp_a: assert property (ips_reg[`PMX_FLT1_BIT] |=>
    fault_o[0] == $past(comparator_a_output_i))
    else $error("fault one not comparator A");
  a_pair_adc_high: assert property (code[2] == `PMX_SRC_ADC &&
    adc_result_i[2] > adc_high_limit_i[2] ##1 code[2] == `PMX_SRC_ADC |=>
    !pair_o[2].even && pair_o[2].odd)
    else $error("pair 4/5 high limit wrong");
  a_pair_adc_low: assert property (code[0] == `PMX_SRC_ADC &&
    adc_result_i[0] < adc_low_limit_i[0] ##1 code[0] == `PMX_SRC_ADC |=>
    pair_o[0].even && !pair_o[0].odd)
    else $error("pair 0/1 low limit wrong");
  a_pair_reserved: assert property (code[1] > `PMX_SRC_CMPB |=> pair_o[1] == 2'h0)
    else $error("reserved code drove pair 2/3");
  a_pair_timer: assert property (code[1] == `PMX_SRC_TMR |=>
    pair_o[1].even == $past(pair_timer_i[1]) && pair_o[1].odd != pair_o[1].even)
    else $error("pair 2/3 not timer");

  c_reg_write: cover property (ack_o && we_i && idx == `PMX_IDX_IPS);
  c_i2c_pin: cover property (take_b[`PMX_PIN_B0] && pin_reg.i2c_scl == 1'b0);
  c_adc_hold: cover property (code[0] == `PMX_SRC_ADC && pair_o[0].even ##3 pair_o[0].even);
  c_unmapped: cover property (ack_o && idx == 6'h00);
endmodule

// ==== hdl/pmx_regs.svh ====
/*
  Register indices, field positions, write masks, reset values and
  source codes of the signal mux. Assumes it is included by bare name.
*/
`ifndef PMX_REGS_SVH
`define PMX_REGS_SVH
`define PMX_IDX_GPSB_LO 6'h15
`define PMX_IDX_GPSB_HI 6'h16
`define PMX_IDX_PCD 6'h17
`define PMX_IDX_IPS 6'h18
`define PMX_RST16 16'h0000
`define PMX_MSK_GPSB_LO 16'h0005
`define PMX_MSK_GPSB_HI 16'h0155
`define PMX_MSK_PCD 16'h1014
`define PMX_MSK_IPS 16'h29FF
`define PMX_B0_BIT 0
`define PMX_B1_BIT 2
`define PMX_B7_BIT 0
`define PMX_B8_BIT 2
`define PMX_B9_BIT 4
`define PMX_B10_BIT 6
`define PMX_B11_BIT 8
`define PMX_C8_BIT 2
`define PMX_C12_BIT 4
`define PMX_D5_BIT 12
`define PMX_FLT2_BIT 13
`define PMX_FLT1_BIT 11
`define PMX_P45_LSB 6
`define PMX_P23_LSB 3
`define PMX_P01_LSB 0
`define PMX_PIN_B0 0
`define PMX_PIN_B1 1
`define PMX_PIN_B7 2
`define PMX_PIN_B8 3
`define PMX_PIN_B9 4
`define PMX_PIN_B10 5
`define PMX_PIN_B11 6
`define PMX_PIN_C8 7
`define PMX_PIN_C12 8
`define PMX_PIN_D5 9
`define PMX_NPIN 10
`define PMX_NEXT 15
`define PMX_SRC_PIN 3'h0
`define PMX_SRC_TMR 3'h1
`define PMX_SRC_ADC 3'h2
`define PMX_SRC_CMPA 3'h3
`define PMX_SRC_CMPB 3'h4
`endif

// ==== hdl/pmx_pkg.sv ====
/*
  Types shared by the signal mux and its surroundings.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pmx_pkg;
  typedef struct packed {
    logic o;
    logic oe;
  } pmx_drv_t;
  typedef struct packed {
    pmx_drv_t spi0_serial_clock;
    pmx_drv_t spi0_slave_select;
    pmx_drv_t i2c_scl;
    pmx_drv_t i2c_sda;
    pmx_drv_t serial0_transmit;
    pmx_drv_t can_transmit_data;
    pmx_drv_t timer_b0;
    pmx_drv_t timer_b1;
    pmx_drv_t serial1_transmit;
    pmx_drv_t crystal_osc_output;
  } pmx_per_out_t;
  typedef struct packed {
    logic spi0_serial_clock;
    logic spi0_slave_select;
    logic i2c_scl;
    logic i2c_sda;
    logic can_receive_data;
    logic serial1_receive;
    logic external_clock_input;
    logic adc_a_channel_four;
    logic adc_b_channel_four;
  } pmx_per_in_t;
  typedef struct packed {
    logic even;
    logic odd;
  } pmx_pair_t;
endpackage

// ==== test/pmx_far_side.sv ====
/*
  Model of what faces the signal mux: peripheral drivers, comparators,
  timers, PWM pins and the package pads.
  Assumes the bench owns ADC values, GPIO, enables and outside pad levels.
*/
`timescale 1ns/1ps
module pmx_far_side (
  input wire logic [9:0] pad_o_i,
  input wire logic [9:0] pad_oe_i,
  input wire logic [9:0] ext_lvl_i,
  output pmx_pkg::pmx_per_out_t per_drv_o,
  output logic cmp_a_o,
  output logic cmp_b_o,
  output logic [2:0] tmr_o,
  output logic [2:0] pair_pin_o,
  output logic [1:0] fault_pin_o,
  output logic [9:0] pad_in_o
);
  import pmx_pkg::*;
  // Both output functions of each pin that has two carry opposite levels, so a wrong pick shows
  assign per_drv_o = {2'h3, 2'h3, 2'h1, 2'h1, 2'h3, 2'h3, 2'h1, 2'h3, 2'h3, 2'h3};
  assign cmp_a_o = 1'b1;
  assign cmp_b_o = 1'b0;
  assign tmr_o = 3'h2;
  assign pair_pin_o = 3'h5;
  assign fault_pin_o = 2'h2;
  // A pad that nobody inside drives follows the outside level
  assign pad_in_o = (pad_oe_i & pad_o_i) | (~pad_oe_i & ext_lvl_i);
endmodule

// ==== test/test_peripheral_signal_mux.sv ====
/*
  Self-checking bench for the signal mux: registers, pin functions,
  fault and pair sources.
  Assumes pmx_far_side beside it and a 50 MHz clock.
*/
`timescale 1ns/1ps
module test_peripheral_signal_mux;
  import pmx_pkg::*;
  logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, cmp_a, cmp_b;
  logic [7:0] adr_i;
  logic [31:0] dat_i, dat_o;
  logic [3:0] sel_i;
  logic [9:0] pad_in, pad_o, pad_oe, gpio_o, gpio_oe, pen, gpio_in, ext_lvl;
  logic [2:0] tmr, ppin;
  logic [1:0] fpin, fault_o;
  logic [2:0][11:0] res, hi, lo;
  logic [15:0] rv;
  pmx_per_out_t per_drv;
  pmx_per_in_t per_in;
  pmx_pair_t [2:0] pair_o;
  int err_total, num_checks;

  pmx_signal_mux #(.ADC_W(12)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .pad_in_i(pad_in), .pad_o(pad_o), .pad_oe_o(pad_oe), .gpio_o_i(gpio_o),
    .gpio_oe_i(gpio_oe), .pin_peripheral_enable_i(pen), .gpio_in_o(gpio_in),
    .per_drv_i(per_drv), .per_in_o(per_in), .comparator_a_output_i(cmp_a),
    .comparator_b_output_i(cmp_b), .pair_timer_i(tmr), .fault_pin_i(fpin),
    .pair_pin_i(ppin), .adc_result_i(res), .adc_high_limit_i(hi),
    .adc_low_limit_i(lo), .fault_o(fault_o), .pair_o(pair_o));

  pmx_far_side far (
    .pad_o_i(pad_o), .pad_oe_i(pad_oe), .ext_lvl_i(ext_lvl), .per_drv_o(per_drv),
    .cmp_a_o(cmp_a), .cmp_b_o(cmp_b), .tmr_o(tmr), .pair_pin_o(ppin),
    .fault_pin_o(fpin), .pad_in_o(pad_in));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic single cycle; request held until the edge that samples ack
  task wb(input logic [7:0] a, input logic w, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk_i);
    adr_i <= a;
    we_i <= w;
    dat_i <= {16'h0000, d};
    sel_i <= 4'h3;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task t_regs;
    logic [7:0] adr [4];
    logic [15:0] msk [4];
    adr = '{8'h54, 8'h58, 8'h5C, 8'h60};
    msk = '{16'h0005, 16'h0155, 16'h1014, 16'h29FF};
    for (int i = 0; i < 4; i++) begin
      wb(adr[i], 1'b0, 16'h0000, rv);
      chk("reset value", 32'h0, {16'h0, rv});
      // Reserved bits written as one on purpose: they must read back zero
      wb(adr[i], 1'b1, 16'hFFFF, rv);
      wb(adr[i], 1'b0, 16'h0000, rv);
      chk("masked readback", {16'h0, msk[i]}, {16'h0, rv});
      wb(adr[i], 1'b1, 16'h0000, rv);
    end
    wb(8'h40, 1'b1, 16'hFFFF, rv);
    wb(8'h40, 1'b0, 16'h0000, rv);
    chk("unmapped read", 32'h0, {16'h0, rv});
  endtask

  task t_gpio;
    @(posedge clk_i);
    pen <= 10'h000;
    gpio_o <= 10'h2A5;
    gpio_oe <= 10'h35A;
    wait_cyc(3);
    chk("gpio pad_o", 32'h2A5, {22'h0, pad_o});
    chk("gpio pad_oe", 32'h35A, {22'h0, pad_oe});
  endtask

  // Both select values of every pin; outside pad level held high
  task t_pins;
    logic [9:0] oe_exp, o_exp;
    logic [4:0] in_exp;
    @(posedge clk_i);
    pen <= 10'h3FF;
    ext_lvl <= 10'h3FF;
    for (int s = 0; s < 2; s++) begin
      wb(8'h54, 1'b1, s ? 16'h0005 : 16'h0000, rv);
      wb(8'h58, 1'b1, s ? 16'h0155 : 16'h0000, rv);
      wb(8'h5C, 1'b1, s ? 16'h1014 : 16'h0000, rv);
      wait_cyc(8);
      oe_exp = s ? 10'h0EF : 10'h27F;
      o_exp = s ? 10'h0C8 : 10'h227;
      in_exp = s ? 5'h1C : 5'h03;
      chk("pin enables", {22'h0, oe_exp}, {22'h0, pad_oe});
      chk("pin levels", {22'h0, o_exp}, {22'h0, pad_o & pad_oe});
      chk("peripheral inputs", {27'h0, in_exp}, {27'h0, per_in.can_receive_data,
        per_in.serial1_receive, per_in.external_clock_input,
        per_in.adc_a_channel_four, per_in.adc_b_channel_four});
      chk("shared inputs", s ? 32'h0 : 32'hC, {28'h0, per_in.spi0_serial_clock,
        per_in.spi0_slave_select, per_in.i2c_scl, per_in.i2c_sda});
      chk("gpio inputs", {22'h0, ~oe_exp | o_exp}, {22'h0, gpio_in});
    end
  endtask

  task t_fault;
    wb(8'h60, 1'b1, 16'h0000, rv);
    wait_cyc(8);
    chk("fault from pins", 32'h2, {30'h0, fault_o});
    wb(8'h60, 1'b1, 16'h2800, rv);
    wait_cyc(3);
    chk("fault from comparators", 32'h1, {30'h0, fault_o});
  endtask

  function automatic logic [1:0] pexp(input int c, input int k, input logic [1:0] st);
    logic s;
    case (c)
      0: s = ppin[k];
      1: s = tmr[k];
      3: s = cmp_a;
      4: s = cmp_b;
      default: s = 1'b0;
    endcase
    if (c == 2)
      return st;
    if (c > 4)
      return 2'b00;
    return {s, ~s};
  endfunction

  // Sample 0 above its high limit, sample 1 below its low, sample 2 between
  task t_pairs;
    logic [5:0] e;
    for (int c = 0; c < 8; c++) begin
      wb(8'h60, 1'b1, 16'(c * 'h49), rv);
      wait_cyc(8);
      e = {pexp(c, 2, 2'b00), pexp(c, 1, 2'b10), pexp(c, 0, 2'b01)};
      chk("pair outputs", {26'h0, e}, {26'h0, pair_o});
    end
    wb(8'h60, 1'b1, 16'h0092, rv);
    @(posedge clk_i);
    res[2] <= 12'h900;
    wait_cyc(3);
    chk("pair 4/5 above", 32'h1, {30'h0, pair_o[2]});
    @(posedge clk_i);
    res[2] <= 12'h400;
    wait_cyc(3);
    chk("pair 4/5 hold", 32'h1, {30'h0, pair_o[2]});
    @(posedge clk_i);
    res[2] <= 12'h050;
    wait_cyc(3);
    chk("pair 4/5 below", 32'h2, {30'h0, pair_o[2]});
  endtask

  initial begin
    #(20 * 20000);
    err_total++;
    end_sim;
  end

  initial begin
    err_total = 0;
    num_checks = 0;
    rst_i = 1'b1;
    {we_i, cyc_i, stb_i} = 3'b000;
    adr_i = 8'h00;
    dat_i = 32'h0;
    sel_i = 4'h0;
    {gpio_o, gpio_oe, pen, ext_lvl} = '0;
    res = {12'h400, 12'h050, 12'h900};
    hi = {3{12'h800}};
    lo = {3{12'h100}};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_cyc(8);
    // Selects reset to pin source, so each pair follows its filtered pin
    chk("pairs after reset", {26'h0, pexp(0, 2, 2'b00), pexp(0, 1, 2'b00),
      pexp(0, 0, 2'b00)}, {26'h0, pair_o});
    t_regs();
    t_gpio();
    t_pins();
    t_fault();
    t_pairs();
    end_sim;
  end
endmodule
